// >>> rtl/pio_regs.svh
// Named constants for the parallel I/O card glue logic.
// Assumes inclusion by the package and the top module only.
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH
`define PIO_PORT_W        8
`define PIO_HALF_W        4
`define PIO_NPORT         3
`define PIO_IRQ_BIT       3
`define PIO_DIR_IN        1'b0
`define PIO_DIR_OUT       1'b1
`define PIO_SEL_INTERNAL  1'b0
`define PIO_SEL_EXTERNAL  1'b1
`define PIO_BUF_TRISTATE  1'b0
`define PIO_BUF_ALWAYS_ON 1'b1
`define PIO_TMR_W         16
`define PIO_TMR_CHANNELS  3
`define PIO_TMR_CHIPS_MAX 3
`define PIO_PIN_IDLE      1'b1
`endif

// >>> rtl/pio_pkg.sv
// Types shared by the parallel I/O card glue logic.
// Assumes the constants header is on the include path.
`include "pio_regs.svh"
package pio_pkg;
  // Direction settings: third port split into two halves
  typedef struct packed {
    logic c_hi;
    logic c_lo;
    logic b;
    logic a;
  } pio_dir_t;

  // Jumper straps, static in operation
  typedef struct packed {
    logic buf_mode;
    logic irq_source_select;
    logic port_irq_jumper;
    logic timer_irq_jumper;
  } pio_jmp_t;

  typedef enum logic [1:0] {
    PIO_IDLE = 2'b01,
    PIO_REQ  = 2'b10
  } pio_irq_st_t;
endpackage : pio_pkg

// >>> rtl/pio_glue.sv
// Glue logic for a 24-line buffered digital I/O card.
// Assumes field pins and jumpers are asynchronous; direction and
// buffer-enable bits come from logic on clk.
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_glue
  import pio_pkg::*;
#(
  // Fitted counter chips, one to three
  parameter int unsigned TMR_CHIPS = 1
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Software configuration
  input  wire pio_dir_t                    dir_cfg,
  input  wire logic                        buf_enable_sw,
  input  wire logic [3*`PIO_PORT_W-1:0]    port_out_data,
  // Jumpers
  input  wire pio_jmp_t                    jumpers,
  // Field side
  input  wire logic [3*`PIO_PORT_W-1:0]    field_in,
  output logic      [3*`PIO_PORT_W-1:0]    field_out,
  output logic      [3*`PIO_PORT_W-1:0]    field_oe,
  input  wire logic                        ext_irq_in,
  input  wire logic                        irq_disable_n,
  // Timer chip and transceivers
  input  wire logic                        timer_channel_two_output,
  output logic      [`PIO_NPORT:0]         xcvr_transmit,
  output logic                             xcvr_enable,
  // Host side
  output logic      [3*`PIO_PORT_W-1:0]    port_in_data,
  output logic                             host_irq
);
  localparam int PW = `PIO_PORT_W;

  // Three-stage synchronisers for all asynchronous inputs
  localparam int JW = $bits(pio_jmp_t);
  localparam int SW = 3*PW + 3 + JW;
  // Pins reset to their idle-high level, jumpers to zero: settling after
  // reset can then only fall, so it never fakes an interrupt edge
  localparam logic [SW-1:0] SYNC_RST = {{(SW-JW){`PIO_PIN_IDLE}},
                                        {JW{1'b0}}};
  logic [SW-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= {field_in, ext_irq_in, irq_disable_n,
               timer_channel_two_output, jumpers};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change once the last two stages agree
  logic [SW-1:0] in_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_q <= SYNC_RST;
    end else begin
      for (int i = 0; i < SW; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          in_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic [3*PW-1:0] fin;
  logic            ext_s, dis_n_s, tmr_s;
  pio_jmp_t        jmp_s;
  assign {fin, ext_s, dis_n_s, tmr_s, jmp_s} = in_q;

  // Directions, reset to input so nothing drives the field
  pio_dir_t dir_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dir_q <= '0;
    end else begin
      dir_q <= dir_cfg;
    end
  end

  // Buffer enable per jumper
  logic buf_en_d, buf_en_q;
  always_comb begin
    if (jmp_s.buf_mode == `PIO_BUF_ALWAYS_ON) begin
      buf_en_d = 1'b1;
    end else begin
      buf_en_d = buf_enable_sw;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      buf_en_q <= 1'b0;
    end else begin
      buf_en_q <= buf_en_d;
    end
  end

  // Lane directions from the registered settings, one bit per line
  logic [3*PW-1:0] lane_dir;
  assign lane_dir = {{`PIO_HALF_W{dir_q.c_hi}},
                     {`PIO_HALF_W{dir_q.c_lo}},
                     {PW{dir_q.b}},
                     {PW{dir_q.a}}};

  // Lane output enables, gated by the buffer enable
  logic [3*PW-1:0] oe_d;
  assign oe_d = lane_dir & {3*PW{buf_en_q}};

  // Transceiver control and lane drive
  always_ff @(posedge clk) begin
    if (!resetn) begin
      field_oe      <= '0;
      xcvr_transmit <= '0;
      xcvr_enable   <= 1'b0;
    end else begin
      field_oe      <= oe_d;
      xcvr_transmit <= dir_q;
      xcvr_enable   <= buf_en_q;
    end
  end

  // Output data, harmless while its lane is not driven
  always_ff @(posedge clk) begin
    if (!resetn) begin
      field_out <= '0;
    end else begin
      field_out <= port_out_data;
    end
  end

  // Field levels towards the host
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_in_data <= '0;
    end else begin
      port_in_data <= fin;
    end
  end

  // Interrupt source selection and edge detection
  logic src_q, tmr_q;
  logic src_now;
  always_comb begin
    if (jmp_s.irq_source_select == `PIO_SEL_EXTERNAL) begin
      src_now = ext_s;
    end else begin
      src_now = fin[2*PW + `PIO_IRQ_BIT];
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Idle level, matching the synchroniser reset
      src_q <= `PIO_PIN_IDLE;
      tmr_q <= `PIO_PIN_IDLE;
    end else begin
      src_q <= src_now;
      tmr_q <= tmr_s;
    end
  end

  // Timer source counts only with a fitted first counter chip
  localparam bit TMR_FITTED = (TMR_CHIPS >= 1) &&
                              (TMR_CHIPS <= `PIO_TMR_CHIPS_MAX);
  logic tmr_en;
  assign tmr_en = jmp_s.timer_irq_jumper & TMR_FITTED;

  logic port_evt, tmr_evt;
  assign port_evt = src_now & ~src_q & jmp_s.port_irq_jumper;
  assign tmr_evt  = tmr_s & ~tmr_q & tmr_en;

  // Request held until source falls; disable input gates it
  pio_irq_st_t st_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= PIO_IDLE;
    end else begin
      case (st_q)
        PIO_IDLE: begin
          if (port_evt || tmr_evt) begin
            st_q <= PIO_REQ;
          end
        end
        PIO_REQ: begin
          if (!(src_now && jmp_s.port_irq_jumper) &&
              !(tmr_s && tmr_en)) begin
            st_q <= PIO_IDLE;
          end
        end
        default: st_q <= PIO_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= (st_q == PIO_REQ) & dis_n_s;
    end
  end

endmodule : pio_glue

// >>> dv/pio_chk.sv
// Port assertions for the I/O glue block.
// Assumes bind by port name into every pio_glue.
`timescale 1ns/1ps
module pio_chk
  import pio_pkg::*;
#(
  parameter int unsigned TMR_CHIPS = 1
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire pio_dir_t    dir_cfg,
  input wire logic        buf_enable_sw,
  input wire pio_jmp_t    jumpers,
  input wire logic [23:0] field_in,
  input wire logic [23:0] field_oe,
  input wire logic        ext_irq_in,
  input wire logic        irq_disable_n,
  input wire logic        timer_channel_two_output,
  input wire logic [3:0]  xcvr_transmit,
  input wire logic        xcvr_enable,
  input wire logic [23:0] port_in_data,
  input wire logic        host_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [23:0] lanes = {{4{xcvr_transmit[3]}}, {4{xcvr_transmit[2]}},
    {8{xcvr_transmit[1]}}, {8{xcvr_transmit[0]}}} & {24{xcvr_enable}};
  a_dir_to_xcvr: assert property (
    $past(resetn, 2) && $past(resetn) |-> xcvr_transmit == $past(dir_cfg, 2))
    else $error("transceiver direction wrong");
  a_oe_per_lane: assert property (field_oe == lanes)
    else $error("lane drive mismatch");
  a_reset_quiet: assert property (disable iff (1'b0)
    !resetn |=> field_oe == '0 && xcvr_transmit == '0 && !host_irq)
    else $error("outputs active in reset");
  a_buf_always_on: assert property (
    jumpers.buf_mode [*8] |-> xcvr_enable)
    else $error("buffer off in always-on");
  a_buf_sw_follow: assert property (
    (!jumpers.buf_mode && $stable(buf_enable_sw)) [*8]
    |-> xcvr_enable == buf_enable_sw) else $error("buffer enable wrong");
  a_irq_disabled: assert property (
    !irq_disable_n [*8] |-> !host_irq)
    else $error("request while disabled");
  a_irq_no_source: assert property (
    (!field_in[19] && !ext_irq_in && !timer_channel_two_output) [*8]
    |-> !host_irq) else $error("request without source");
  a_in_data_sync: assert property ($stable(field_in) [*8]
    |-> port_in_data == field_in) else $error("input data stale");
  cover property ($rose(host_irq));
  cover property (&field_oe);
  cover property ($fell(xcvr_enable));
endmodule : pio_chk
bind pio_glue pio_chk #(.TMR_CHIPS(TMR_CHIPS)) chk (.*);

// >>> dv/pio_field.sv
// Field wiring model: reads back driven lanes, supplies the rest.
// Assumes the bench picks the level of undriven lanes.
`timescale 1ns/1ps
module pio_field (
  input  wire logic [23:0] field_out,
  input  wire logic [23:0] field_oe,
  input  wire logic [23:0] lvl,
  output logic      [23:0] field_in
);
  assign field_in = (field_out & field_oe) | (lvl & ~field_oe);
endmodule : pio_field

// >>> dv/parallel_io_card_glue_test.sv
// Self-checking bench for the I/O glue block.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module parallel_io_card_glue_test;
  import pio_pkg::*;
  logic        clk = 0, resetn = 0, sw = 0, external_source_position = 0, dis_n = 1, tmr = 0;
  pio_dir_t    dir = '0;
  pio_jmp_t    jmp = '0;
  logic [23:0] pod = '0, lvl = '0, fin, fout, foe, pin, l;
  logic [3:0]  xt;
  logic        xe, irq;
  int          fails = 0, samples_checked = 0;
  always #2 clk = ~clk;
  pio_glue uut (.clk(clk), .resetn(resetn), .dir_cfg(dir),
    .buf_enable_sw(sw), .port_out_data(pod), .jumpers(jmp),
    .field_in(fin), .field_out(fout), .field_oe(foe), .ext_irq_in(external_source_position),
    .irq_disable_n(dis_n), .timer_channel_two_output(tmr),
    .xcvr_transmit(xt), .xcvr_enable(xe), .port_in_data(pin),
    .host_irq(irq));
  pio_field fw (.field_out(fout), .field_oe(foe), .lvl(lvl), .field_in(fin));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic check(string n, logic [23:0] seen, logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  function automatic logic [23:0] exp_lanes(pio_dir_t d);
    return {{4{d.c_hi}}, {4{d.c_lo}}, {8{d.b}}, {8{d.a}}};
  endfunction : exp_lanes
  function automatic logic exp_irq(pio_jmp_t j, logic b, e, t, d);
    logic src;
    src = j.irq_source_select ? e : b;
    return d & ((j.port_irq_jumper & src) | (j.timer_irq_jumper & t));
  endfunction : exp_irq
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Sources idle first so jumper changes settle before the edge
  task automatic irq_case(pio_jmp_t j, logic b, logic e, logic t, logic d);
    logic x;
    {lvl[19], external_source_position, tmr} = 3'h0;
    jmp = j;
    dis_n = d;
    tick(12);
    {lvl[19], external_source_position, tmr} = {b, e, t};
    x = exp_irq(j, b, e, t, d);
    tick(12);
    check("irq", {23'h0, irq}, {23'h0, x});
  endtask : irq_case
  initial begin
    #20000;
    fails++;
    complete_run();
  end
  initial begin
    int unsigned r;
    void'($urandom(32'hCEB8B1AF));
    tick(10);
    check("reset oe", foe, 24'h0);
    check("reset xcvr irq", {18'h0, xt, xe, irq}, 24'h0);
    resetn = 1;
    jmp = 4'h8;
    for (int i = 0; i < 16; i++) begin
      dir = pio_dir_t'(4'(i));
      l = exp_lanes(dir);
      pod = 24'($urandom);
      lvl = 24'($urandom);
      tick(12);
      check("xcvr_transmit", {20'h0, xt}, {20'h0, dir});
      check("field_oe", foe, l);
      check("port_in_data", pin, (pod & l) | (lvl & ~l));
    end
    jmp = 4'h0;
    for (int i = 0; i < 4; i++) begin
      sw = i[0];
      tick(10);
      check("field_oe", foe, {24{i[0]}});
    end
    resetn = 0;
    tick(3);
    check("oe after reset", foe, 24'h0);
    check("dir after reset", {19'h0, xt, xe}, 24'h0);
    resetn = 1;
    dir = '0;
    irq_case('0, 1, 0, 0, 1);
    jmp = 4'h2;
    tick(12);
    check("held level", {23'h0, irq}, 24'h0);
    for (int i = 0; i < 32; i++) begin
      r = $urandom;
      irq_case(pio_jmp_t'(i[3:0]), r[0], r[1], r[2], i[4] | r[3]);
    end
    // Level held high across a reset must not look like a new edge
    irq_case(4'h2, 1, 0, 0, 1);
    resetn = 0;
    tick(3);
    resetn = 1;
    tick(12);
    check("level across reset", {23'h0, irq}, 24'h0);
    complete_run();
  end
endmodule : parallel_io_card_glue_test
